// ---- core/chpt_pkg.sv ----
// Package: chopper timing constants, field layout and types
package chpt_pkg;

  // ********************************************************
  // Configuration word layout
  // ********************************************************
  localparam int CFG_W = 20;
  localparam int TBL_LSB = 15;
  localparam int CHM_BIT = 14;
  localparam int RND_BIT = 13;
  localparam int HYSTERESIS_DECREMENT_SEL_LSB = 11;
  localparam int HYSTERESIS_END_OR_OFFSET_LSB = 7;
  localparam int HYSTERESIS_START_OR_FAST_TIME_LSB = 4;
  localparam int SLOW_DECAY_OFF_TIME_LSB = 0;
  localparam logic [CFG_W-1:0] CFG_RESET = 20'h00000;
  localparam logic [1:0] ADDR_CFG = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;

  // ********************************************************
  // Timing constants in system clock periods
  // ********************************************************
  localparam int CLK_MHZ = 100;
  localparam logic [7:0] BLANK_16 = 8'h10;
  localparam logic [7:0] BLANK_24 = 8'h18;
  localparam logic [7:0] BLANK_36 = 8'h24;
  localparam logic [7:0] BLANK_54 = 8'h36;
  localparam logic [9:0] SLOW_BASE = 10'h018;
  localparam int SLOW_SHIFT = 5;
  localparam int FAST_SHIFT = 5;
  localparam int HYSTERESIS_DECREMENT_SEL_SHIFT = 4;
  localparam logic [4:0] HYSTERESIS_END_OR_OFFSET_BIAS = 5'h03;
  localparam logic [3:0] RND_SPAN = 4'ha;
  localparam logic [3:0] RND_MID = 4'h4;

  typedef enum logic [3:0] {
    PH_OFF  = 4'b0001,
    PH_ON   = 4'b0010,
    PH_FAST = 4'b0100,
    PH_SLOW = 4'b1000
  } chpt_phase_e;

  typedef struct packed {
    logic [1:0] blank_time_sel;
    logic chopper_mode_select;
    logic random_off_time_en;
    logic [1:0] hysteresis_decrement_sel;
    logic [3:0] hysteresis_end_or_offset;
    logic [2:0] hysteresis_start_or_fast_time;
    logic [3:0] slow_decay_off_time;
  } chpt_cfg_s;

  typedef struct packed {
    logic high_a;
    logic low_a;
    logic high_b;
    logic low_b;
  } chpt_bridge_s;

endpackage : chpt_pkg

// ---- core/chpt_coil.sv ----
// One coil's chopper phase sequencer
`timescale 1ns/100ps
module chpt_coil
(
  input wire logic clk,
  input wire logic rst,
  input wire chpt_pkg::chpt_cfg_s cfg,
  input wire logic [7:0] blank_cyc,
  input wire logic [3:0] rnd,
  input wire logic above_peak,
  input wire logic below_neg,
  output logic drive_on,
  output logic drive_rev,
  output logic [3:0] phase,
  output logic [4:0] hyst
);

  chpt_pkg::chpt_phase_e st_q, st_d;
  logic [10:0] cnt_q;
  logic [7:0] blank_q;
  logic [6:0] dec_q;
  logic [4:0] hyst_q;
  wire logic disabled = (cfg.slow_decay_off_time == 4'h0);
  wire logic blanked = (blank_q != 8'h00);
  wire logic cmode = cfg.chopper_mode_select;
  wire logic [3:0] fast_n = {cfg.hysteresis_decrement_sel[0],
                              cfg.hysteresis_start_or_fast_time};
  // A zero fast decay time skips the fast phase so its timer cannot stall
  wire logic use_fast = cmode && (fast_n != 4'h0);
  wire logic [10:0] fast_cyc = 11'({fast_n, 5'h00});
  wire logic [10:0] slow_nom = 11'(chpt_pkg::SLOW_BASE)
    + 11'({cfg.slow_decay_off_time, 5'h00});
  // Random modulation spreads around the nominal off time
  wire logic [10:0] slow_cyc = cfg.random_off_time_en
    ? slow_nom + 11'(rnd) - 11'(chpt_pkg::RND_MID) : slow_nom;
  wire logic [6:0] dec_cyc = 7'({cfg.hysteresis_decrement_sel, 4'h0})
    + 7'h10;
  wire logic [4:0] hstart = 5'(cfg.hysteresis_end_or_offset)
    + 5'(cfg.hysteresis_start_or_fast_time) + 5'h01;
  wire logic timer_done = (cnt_q == 11'h001);
  wire logic fast_cmp = ~cfg.hysteresis_decrement_sel[1];
  wire logic ph_change = (st_d != st_q);

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      chpt_pkg::PH_OFF: if (!disabled) st_d = chpt_pkg::PH_ON;
      chpt_pkg::PH_ON:
        if (!blanked && above_peak)
          st_d = use_fast ? chpt_pkg::PH_FAST : chpt_pkg::PH_SLOW;
      chpt_pkg::PH_FAST:
        if (timer_done || (fast_cmp && !blanked && below_neg))
          st_d = chpt_pkg::PH_SLOW;
      chpt_pkg::PH_SLOW: if (timer_done) st_d = chpt_pkg::PH_ON;
      default: st_d = chpt_pkg::PH_OFF;
    endcase
    if (disabled)
      st_d = chpt_pkg::PH_OFF;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= chpt_pkg::PH_OFF;
      cnt_q <= 11'h000;
      blank_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      if (ph_change)
      begin
        blank_q <= blank_cyc;
        cnt_q <= (st_d == chpt_pkg::PH_FAST) ? fast_cyc
          : slow_cyc;
      end
      else
      begin
        if (blanked)
          blank_q <= blank_q - 8'h01;
        if (cnt_q != 11'h000)
          cnt_q <= cnt_q - 11'h001;
      end
    end
  end

  // Hysteresis steps down from start toward end during the cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dec_q <= 7'h00;
      hyst_q <= chpt_pkg::HYSTERESIS_END_OR_OFFSET_BIAS;
    end
    else if (st_q != chpt_pkg::PH_ON && st_d == chpt_pkg::PH_ON)
    begin
      dec_q <= dec_cyc;
      hyst_q <= hstart;
    end
    else if (dec_q > 7'h01)
      dec_q <= dec_q - 7'h01;
    else
    begin
      dec_q <= dec_cyc;
      if (hyst_q > 5'(cfg.hysteresis_end_or_offset))
        hyst_q <= hyst_q - 5'h01;
    end
  end

  assign phase = st_q;
  assign hyst = cmode ? 5'h00 : hyst_q;
  assign drive_on = (st_q == chpt_pkg::PH_ON);
  assign drive_rev = (st_q == chpt_pkg::PH_FAST);

endmodule : chpt_coil

// ---- core/chpt_top.sv ----
// Chopper phase timing for a two-coil stepper driver
// Summary of operation
// - Ignore comparator for 16/24/36/54 clock blanking
// - Mode bit picks hysteresis or constant off-time
// - Off-time mode: fast decay follows on, ends at timer or negative current
// - Random bit modulates slow decay around off time
// - Hysteresis decrement period 16/32/48/64 clocks
// - Decrement upper bit picks fast decay end
// - End code maps to hysteresis -3 to 12
// - Same code gives sine offset -3 to 12
// - Start code adds 1 to 8 above end
// - Fast decay lasts 32 times four-bit value
// - Slow decay lasts 24 plus 32 times off time
// - Off time zero switches every bridge off
`timescale 1ns/100ps
module chpt_top
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // Register port
  input wire logic [1:0] ADDR_IN,
  input wire logic [19:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [19:0] RDATA_OUT,
  // Coil comparators (asynchronous pins)
  input wire logic CMP_PEAK_A_IN,
  input wire logic CMP_NEG_A_IN,
  input wire logic CMP_PEAK_B_IN,
  input wire logic CMP_NEG_B_IN,
  // Bridge gates and current adjustments
  output chpt_pkg::chpt_bridge_s BRIDGE_OUT,
  output logic [4:0] HYST_A_OUT,
  output logic [4:0] HYST_B_OUT,
  output logic signed [4:0] SINE_OFFSET_OUT
);

  // ********************************************************
  // Configuration register
  // ********************************************************
  chpt_pkg::chpt_cfg_s cfg_q;
  logic [19:0] rdata_q;
  logic [15:0] lfsr_q;
  logic [3:0] sy1_q, sy2_q;
  wire logic [3:0] ph_a, ph_b;
  wire logic on_a, rev_a, on_b, rev_b;
  wire logic [4:0] hy_a, hy_b;
  wire logic wr_cfg = WR_IN && (ADDR_IN == chpt_pkg::ADDR_CFG);
  wire logic [19:0] status = {12'h000, ph_b, ph_a};

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      cfg_q <= chpt_pkg::chpt_cfg_s'(17'h00000);
    else if (wr_cfg)
      cfg_q <= chpt_pkg::chpt_cfg_s'(WDATA_IN[16:0]);
  end

  // Config is write-only; reads return phase status or zero
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      rdata_q <= chpt_pkg::CFG_RESET;
    else if (RD_IN && ADDR_IN == chpt_pkg::ADDR_STATUS)
      rdata_q <= status;
    else
      rdata_q <= 20'h00000;
  end

  assign RDATA_OUT = rdata_q;

  // ********************************************************
  // Shared decode and random source
  // ********************************************************
  function automatic logic [7:0] blank_of(input logic [1:0] sel);
    unique case (sel)
      2'h0: blank_of = chpt_pkg::BLANK_16;
      2'h1: blank_of = chpt_pkg::BLANK_24;
      2'h2: blank_of = chpt_pkg::BLANK_36;
      default: blank_of = chpt_pkg::BLANK_54;
    endcase
  endfunction : blank_of

  wire logic [7:0] blank_cyc = blank_of(cfg_q.blank_time_sel);

  // Pseudo-random; only spread matters, not quality
  wire logic [3:0] rnd_raw = lfsr_q[3:0];
  wire logic [3:0] rnd = (rnd_raw > chpt_pkg::RND_SPAN)
    ? rnd_raw - chpt_pkg::RND_SPAN : rnd_raw;

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      lfsr_q <= 16'hace1;
    else
      lfsr_q <= {lfsr_q[14:0],
                 lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      sy1_q <= 4'h0;
      sy2_q <= 4'h0;
    end
    else
    begin
      sy1_q <= {CMP_NEG_B_IN, CMP_PEAK_B_IN, CMP_NEG_A_IN, CMP_PEAK_A_IN};
      sy2_q <= sy1_q;
    end
  end

  // ********************************************************
  // Coil sequencers
  // ********************************************************
  chpt_coil u_coil_a
  (
    .clk(CLK_IN),
    .rst(RST_IN),
    .cfg(cfg_q),
    .blank_cyc(blank_cyc),
    .rnd(rnd),
    .above_peak(sy2_q[0]),
    .below_neg(sy2_q[1]),
    .drive_on(on_a),
    .drive_rev(rev_a),
    .phase(ph_a),
    .hyst(hy_a)
  );

  chpt_coil u_coil_b
  (
    .clk(CLK_IN),
    .rst(RST_IN),
    .cfg(cfg_q),
    .blank_cyc(blank_cyc),
    .rnd(rnd),
    .above_peak(sy2_q[2]),
    .below_neg(sy2_q[3]),
    .drive_on(on_b),
    .drive_rev(rev_b),
    .phase(ph_b),
    .hyst(hy_b)
  );

  // Slow decay recirculates low side; off phase drives nothing
  assign BRIDGE_OUT = '{high_a: on_a, low_a: rev_a || ph_a[3],
                        high_b: on_b, low_b: rev_b || ph_b[3]};
  // No hysteresis applies in constant off-time mode
  assign HYST_A_OUT = cfg_q.chopper_mode_select ? 5'h00
    : hy_a - chpt_pkg::HYSTERESIS_END_OR_OFFSET_BIAS;
  assign HYST_B_OUT = cfg_q.chopper_mode_select ? 5'h00
    : hy_b - chpt_pkg::HYSTERESIS_END_OR_OFFSET_BIAS;
  assign SINE_OFFSET_OUT = cfg_q.chopper_mode_select
    ? 5'(cfg_q.hysteresis_end_or_offset) - chpt_pkg::HYSTERESIS_END_OR_OFFSET_BIAS
    : 5'h00;

endmodule : chpt_top

// ---- bench/chpt_coil_model.sv ----
// Comparator model for one coil and its bridge
`timescale 1ns/100ps
module chpt_coil_model
(
  // Bridge side
  input wire logic clk_in,
  input wire logic on_in,
  input wire logic [7:0] rise_in,
  input wire logic [7:0] fall_in,
  // Comparators
  output logic peak_out = 1'b0,
  output logic neg_out = 1'b0
);
  logic [9:0] n_q = 10'h0;
  logic on_q = 1'b0;
  // Current ramps while driven, falls otherwise; no reset needed
  always_ff @(posedge clk_in)
  begin
    on_q <= on_in;
    n_q <= (on_in != on_q) ? 10'h0 : n_q + 10'h1;
    peak_out <= on_in && on_q && n_q >= {2'h0, rise_in};
    neg_out <= !on_in && !on_q && n_q >= {2'h0, fall_in};
  end
endmodule : chpt_coil_model

// ---- bench/chpt_top_chk.sv ----
// Port checks for the chopper timing block
`timescale 1ns/100ps
module chpt_top_chk
(
  // Clock, reset, register port
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [1:0] ADDR_IN,
  input wire logic [19:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [19:0] RDATA_OUT,
  // Outputs
  input wire chpt_pkg::chpt_bridge_s BRIDGE_OUT,
  input wire logic [4:0] HYST_A_OUT,
  input wire logic [4:0] HYST_B_OUT,
  input wire logic signed [4:0] SINE_OFFSET_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  chpt_pkg::chpt_cfg_s c_q;
  logic [1:0] st_q;
  logic v_q, h_q;
  logic [10:0] n_q;
  wire wr = WR_IN && ADDR_IN == 2'h0;
  wire hi = BRIDGE_OUT.high_a;
  wire m1 = c_q.chopper_mode_select;
  wire [3:0] e = c_q.hysteresis_end_or_offset;
  wire [2:0] s = c_q.hysteresis_start_or_fast_time;
  wire [1:0] hd = c_q.hysteresis_decrement_sel;
  wire [1:0] tb = c_q.blank_time_sel;
  wire [10:0] blk = tb[1] ? (tb[0] ? 11'h36 : 11'h24)
    : (tb[0] ? 11'h18 : 11'h10);
  wire [10:0] ex = 11'h18 + {2'h0, c_q.slow_decay_off_time, 5'h0}
    + (m1 ? {2'h0, hd[0], s, 5'h0} : 11'h0);
  wire [4:0] so = m1 ? {1'b0, e} - 5'h3 : 5'h0;
  wire [4:0] hp = HYST_A_OUT + 5'h3;
  wire fix = !c_q.random_off_time_en && (!m1 || hd[1]);
  // Only phases begun under the current settings are judged
  always_ff @(posedge CLK_IN)
  begin
    h_q <= hi;
    n_q <= (hi != h_q) ? 11'h1 : n_q + 11'h1;
    st_q <= (RST_IN || wr) ? 2'h0 : st_q + {1'b0, st_q != 2'h3};
    v_q <= !(RST_IN || wr) && (v_q || (hi != h_q && st_q == 2'h3));
    if (RST_IN)
      c_q <= 17'h00000;
    else if (wr)
      c_q <= WDATA_IN[16:0];
  end
  sequence on_rise; hi && !h_q; endsequence
  sequence on_fall; h_q && !hi; endsequence
  off_bridge_a:
    assert property (wr && WDATA_IN[3:0] == 4'h0 |->
      ##2 (BRIDGE_OUT == 4'h0) [*3]) else $error("bridge on when off");
  unmapped_rd_a:
    assert property (RD_IN && ADDR_IN > 2'h1 |=> RDATA_OUT == 20'h0)
      else $error("unmapped read not zero");
  sine_off_a:
    assert property (st_q == 2'h3 |-> SINE_OFFSET_OUT == so)
      else $error("sine offset wrong");
  hyst_zero_a:
    assert property (v_q && m1 |-> HYST_A_OUT == 5'h0 && HYST_B_OUT == 5'h0)
      else $error("hysteresis in off-time mode");
  blank_min_a:
    assert property (v_q ##0 on_fall |-> n_q >= blk)
      else $error("on phase shorter than blanking");
  off_exact_a:
    assert property (v_q && fix ##0 on_rise |-> n_q == ex)
      else $error("off length wrong");
  rnd_span_a:
    assert property (v_q && c_q.random_off_time_en && !m1 ##0 on_rise
      |-> n_q >= ex - 11'h4 && n_q <= ex + 11'h6) else $error("random span");
  hyst_range_a:
    assert property (v_q && !m1 && hi && h_q |-> hp >= {1'b0, e}
      && hp <= {1'b0, e} + {2'h0, s} + 5'h1) else $error("hysteresis range");
endmodule : chpt_top_chk

// ---- bench/tb_chpt_top.sv ----
// Self-checking bench for the chopper timing block
`timescale 1ns/100ps
module tb_chpt_top;
  logic CLK_IN = 1'b0, RST_IN = 1'b1, WR_IN = 1'b0, RD_IN = 1'b0;
  logic [1:0] ADDR_IN = 2'h0;
  logic [19:0] WDATA_IN = 20'h0, RDATA_OUT;
  logic CMP_PEAK_A_IN, CMP_NEG_A_IN, CMP_PEAK_B_IN, CMP_NEG_B_IN;
  chpt_pkg::chpt_bridge_s BRIDGE_OUT;
  logic [4:0] HYST_A_OUT, HYST_B_OUT;
  logic signed [4:0] SINE_OFFSET_OUT;
  int n_fail = 0;
  int num_checks = 0;
  always #5 CLK_IN = ~CLK_IN;
  chpt_top u_dut (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .CMP_PEAK_A_IN(CMP_PEAK_A_IN),
    .CMP_NEG_A_IN(CMP_NEG_A_IN), .CMP_PEAK_B_IN(CMP_PEAK_B_IN),
    .CMP_NEG_B_IN(CMP_NEG_B_IN), .BRIDGE_OUT(BRIDGE_OUT),
    .HYST_A_OUT(HYST_A_OUT), .HYST_B_OUT(HYST_B_OUT),
    .SINE_OFFSET_OUT(SINE_OFFSET_OUT));
  // Coil B ramps slower so the two coils drift apart
  chpt_coil_model u_ma (.clk_in(CLK_IN), .on_in(BRIDGE_OUT.high_a),
    .rise_in(8'h04), .fall_in(8'h05), .peak_out(CMP_PEAK_A_IN),
    .neg_out(CMP_NEG_A_IN));
  chpt_coil_model u_mb (.clk_in(CLK_IN), .on_in(BRIDGE_OUT.high_b),
    .rise_in(8'h30), .fall_in(8'h05), .peak_out(CMP_PEAK_B_IN),
    .neg_out(CMP_NEG_B_IN));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [19:0] d);
    @(posedge CLK_IN);
    ADDR_IN <= 2'h0;
    WDATA_IN <= d;
    WR_IN <= 1'b1;
    @(posedge CLK_IN);
    WR_IN <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [19:0] d);
    @(posedge CLK_IN);
    ADDR_IN <= a;
    RD_IN <= 1'b1;
    @(posedge CLK_IN);
    RD_IN <= 1'b0;
    #1 d = RDATA_OUT;
  endtask : rd
  // Counts cycles while coil A high side is in state v
  task automatic run(input logic v, output int n);
    for (n = 0; BRIDGE_OUT.high_a === v; n++)
    begin
      if (n > 3000)
        wrap_up(1'b1);
      @(posedge CLK_IN);
      #1;
    end
  endtask : run
  task automatic off_len(output int n);
    #1;
    run(1'b0, n);
    run(1'b1, n);
    run(1'b0, n);
  endtask : off_len
  task automatic phase_a(input logic [3:0] p);
    logic [19:0] d;
    int n;
    run(1'b1, n);
    rd(2'h1, d);
    chk({16'h0, d[3:0]}, {16'h0, p});
  endtask : phase_a
  task automatic s_off;
    logic [19:0] d;
    rd(2'h1, d);
    chk(d, 20'h00011);
    rd(2'h2, d);
    chk(d, 20'h0);
    wr(20'h1fff0);
    repeat (3) @(posedge CLK_IN);
    #1 chk({16'h0, BRIDGE_OUT}, 20'h0);
  endtask : s_off
  task automatic s_hyst;
    int n;
    wr(20'h082b2);
    off_len(n);
    chk({15'h0, HYST_A_OUT}, 20'h00006);
    repeat (16) @(posedge CLK_IN);
    #1 chk({15'h0, HYST_A_OUT}, 20'h00005);
    off_len(n);
    chk(20'(n), 20'h00058);
    phase_a(4'h8);
  endtask : s_hyst
  task automatic s_fast;
    int n;
    wr(20'h0d811);
    off_len(n);
    off_len(n);
    chk(20'(n), 20'h00158);
    chk({15'h0, SINE_OFFSET_OUT}, 20'h0001d);
    chk({15'h0, HYST_B_OUT}, 20'h00000);
    phase_a(4'h4);
    wr(20'h0c811);
    off_len(n);
    off_len(n);
    chk(20'(n < 344), 20'h1);
  endtask : s_fast
  task automatic s_rnd;
    int n;
    wr(20'h12003);
    off_len(n);
    repeat (4)
    begin
      off_len(n);
      chk(20'(n >= 116 && n <= 126), 20'h1);
    end
  endtask : s_rnd
  task automatic wrap_up(input logic tmo);
    if (tmo)
      n_fail++;
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (12) @(posedge CLK_IN);
    RST_IN <= 1'b0;
    s_off();
    s_hyst();
    s_fast();
    s_rnd();
    wrap_up(1'b0);
  end
endmodule : tb_chpt_top
bind chpt_top chpt_top_chk u_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
  .RDATA_OUT(RDATA_OUT), .BRIDGE_OUT(BRIDGE_OUT), .HYST_A_OUT(HYST_A_OUT),
  .HYST_B_OUT(HYST_B_OUT), .SINE_OFFSET_OUT(SINE_OFFSET_OUT));
